// ### src/parallel_io_port_config.sv
// Two three-port peripheral interface units giving 48 configurable lines
// Overview of operation
// RQ1: Forty-eight configurable lines from two identical units of three ports each; here only ports 1 and 2 have handshake modes, ports 3-6 are simple only.
// RQ2: Each port is configured independently as input, output or bidirectional within limits.
// RQ3: Strobed modes on port 1 or 2, or port 1 bidirectional, dedicate port 3 to handshakes.
// RQ4: Only ports 1 and 2 do strobed modes; only port 1 does bidirectional.
// RQ5: Peripherals exchange strobes on port 3 lines and data is latched on them.
// RQ6: Ports 1-5 are eight bits, port 6 two halves; ports 3-6 simple only.
// RQ7: Maskable request when input buffer fills or output byte is taken.
`timescale 1ns/1ps
`default_nettype none
module parallel_io_port_config (
    input  wire logic                           clk,
    input  wire logic                           resetn,
    input  wire pio_pkg::port_mode_t            port1_mode,
    input  wire pio_pkg::port_mode_t            port2_mode,
    input  wire logic [4:0]                     simple_dir,
    input  wire logic [1:0]                     int_en,
    input  wire logic [pio_pkg::SEL_W-1:0]      cpu_sel,
    input  wire logic                           cpu_wr,
    input  wire logic                           cpu_rd,
    input  wire logic [pio_pkg::PORT_W-1:0]     cpu_wdata,
    output logic      [pio_pkg::PORT_W-1:0]     cpu_rdata,
    output logic      [1:0]                     irq,
    input  wire logic [pio_pkg::NUM_LINES-1:0]  line_in,
    output logic      [pio_pkg::NUM_LINES-1:0]  line_out,
    output logic      [pio_pkg::NUM_LINES-1:0]  line_oe
);
    import pio_pkg::*;
    port_mode_t            mode [2];
    logic [NUM_LINES-1:0]  sync1;
    logic [NUM_LINES-1:0]  sync2;
    logic [PORT_W-1:0]     ctl_prev;
    logic [PORT_W-1:0]     ctl_now;
    logic                  ctrl_port;
    logic [1:0]            stb_fall;
    logic [1:0]            ack_fall;
    logic [PORT_W-1:0]     in_latch [2];
    logic [PORT_W-1:0]     out_latch [2];
    logic [1:0]            in_full;
    logic [1:0]            out_full;
    logic [PORT_W-1:0]     simple_out [NUM_PORTS];
    logic [PORT_W-1:0]     next_simple_out [NUM_PORTS];
    logic [PORT_W-1:0]     next_rdata;
    logic [NUM_LINES-1:0]  next_line_out;
    logic [NUM_LINES-1:0]  next_line_oe;
    logic [PORT_W-1:0]     status;

    // Port 2 cannot run bidirectional; it falls back to plain input
    assign mode[0] = port1_mode; // [RQ4]
    assign mode[1] = (port2_mode == mode_bidir) ? mode_in : port2_mode; // [RQ4]

    // Any strobed or bidirectional use takes port 3 over
    assign ctrl_port = (mode[0] inside {mode_strobe_in, mode_strobe_out, mode_bidir})
                    || (mode[1] inside {mode_strobe_in, mode_strobe_out}); // [RQ3]

    // Two-stage synchroniser on every line, plus edge history for port 3
    always_ff @(posedge clk) begin
        if (!resetn) begin
            // Idle high like the active-low handshakes: no false edge or bidir drive after reset
            sync1    <= '1;
            sync2    <= '1;
            ctl_prev <= '1;
        end else begin
            sync1    <= line_in;
            sync2    <= sync1;
            ctl_prev <= ctl_now;
        end
    end

    assign ctl_now = sync2[2*PORT_W +: PORT_W];
    // Handshake inputs are active low; act on the falling edge
    assign stb_fall[0] = ctrl_port && ctl_prev[CB_STB_1] && !ctl_now[CB_STB_1]; // [RQ5]
    assign ack_fall[0] = ctrl_port && ctl_prev[CB_ACK_1] && !ctl_now[CB_ACK_1]; // [RQ5]
    assign stb_fall[1] = ctrl_port && ctl_prev[CB_HS_2] && !ctl_now[CB_HS_2];
    assign ack_fall[1] = stb_fall[1];

    generate
        for (genvar i = 0; i < 2; i++) begin : g_chan
            strobe_channel u_chan (
                .clk         (clk),
                .resetn      (resetn),
                .mode        (mode[i]),
                .strobe_fall (stb_fall[i]),
                .ack_fall    (ack_fall[i]),
                .pin_data    (sync2[i*PORT_W +: PORT_W]),
                .cpu_wr      (cpu_wr && (cpu_sel == SEL_W'(i))),
                .cpu_rd      (cpu_rd && (cpu_sel == SEL_W'(i))),
                .wr_data     (cpu_wdata),
                .int_en      (int_en[i]),
                .in_latch    (in_latch[i]),
                .out_latch   (out_latch[i]),
                .in_full     (in_full[i]),
                .out_full    (out_full[i]),
                .irq         (irq[i])
            ); // [RQ7]
        end
    endgenerate

    // Status seen when port 3 is read as the control port
    always_comb begin
        status             = ctl_now;
        status[CB_INTR_1]  = irq[0];
        status[CB_IBF_1]   = in_full[0];
        status[CB_OBF_1]   = !out_full[0];
        status[CB_INTR_2]  = irq[1];
        status[CB_FLAG_2]  = (mode[1] == mode_strobe_in) ? in_full[1] : !out_full[1];
    end

    // Output latches for the simple-only ports 3 to 6
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_simple_out[p] = simple_out[p];
            if (cpu_wr && (cpu_sel == SEL_W'(p)) && p >= 2) begin
                next_simple_out[p] = cpu_wdata; // [RQ6]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                simple_out[p] <= RST_BYTE;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                simple_out[p] <= next_simple_out[p];
            end
        end
    end

    // Line drivers: each port steered by its own setting, except port 3 while it carries handshakes
    always_comb begin
        next_line_out = RST_LINES;
        next_line_oe  = RST_LINES;
        for (int i = 0; i < 2; i++) begin
            next_line_out[i*PORT_W +: PORT_W] = out_latch[i]; // [RQ2]
            case (mode[i])
                mode_out, mode_strobe_out: begin
                    next_line_oe[i*PORT_W +: PORT_W] = '1;
                end
                mode_bidir: begin
                    // Port 1 drives only while the peripheral holds ack low
                    next_line_oe[i*PORT_W +: PORT_W] = {PORT_W{!ctl_now[CB_ACK_1]}}; // [RQ4]
                end
                default: begin
                    next_line_oe[i*PORT_W +: PORT_W] = '0;
                end
            endcase
        end
        // Ports 3 to 5 whole, port 6 as two halves
        for (int p = 2; p < 5; p++) begin
            next_line_out[p*PORT_W +: PORT_W] = simple_out[p];
            next_line_oe[p*PORT_W +: PORT_W]  = {PORT_W{simple_dir[p-2]}}; // [RQ6]
        end
        next_line_out[5*PORT_W +: PORT_W]          = simple_out[5];
        next_line_oe[5*PORT_W +: HALF_W]           = {HALF_W{simple_dir[3]}}; // [RQ6]
        next_line_oe[5*PORT_W+HALF_W +: HALF_W]    = {HALF_W{simple_dir[4]}}; // [RQ6]
        if (ctrl_port) begin
            next_line_out[2*PORT_W +: PORT_W] = status; // [RQ3]
            next_line_oe[2*PORT_W +: PORT_W]  = '0;
            if (mode[0] inside {mode_strobe_in, mode_bidir}) begin
                next_line_oe[2*PORT_W + CB_IBF_1] = 1'b1;
            end
            if (mode[0] inside {mode_strobe_out, mode_bidir}) begin
                next_line_oe[2*PORT_W + CB_OBF_1] = 1'b1;
            end
            if (mode[0] != mode_in && mode[0] != mode_out) begin
                next_line_oe[2*PORT_W + CB_INTR_1] = 1'b1;
            end
            if (mode[1] inside {mode_strobe_in, mode_strobe_out}) begin
                next_line_oe[2*PORT_W + CB_FLAG_2] = 1'b1;
                next_line_oe[2*PORT_W + CB_INTR_2] = 1'b1;
            end
        end
    end

    // Read data: latched byte in strobed modes, pins or latch otherwise
    always_comb begin
        next_rdata = cpu_rdata;
        if (cpu_rd) begin
            if (cpu_sel < SEL_P3) begin
                case (mode[cpu_sel[0]])
                    mode_strobe_in, mode_bidir: begin
                        next_rdata = in_latch[cpu_sel[0]];
                    end
                    mode_out, mode_strobe_out: begin
                        next_rdata = out_latch[cpu_sel[0]];
                    end
                    default: begin
                        next_rdata = sync2[cpu_sel*PORT_W +: PORT_W];
                    end
                endcase
            end else if (cpu_sel == SEL_P3 && ctrl_port) begin
                next_rdata = status; // [RQ3]
            end else if (cpu_sel < SEL_W'(NUM_PORTS)) begin
                for (int b = 0; b < PORT_W; b++) begin
                    next_rdata[b] = next_line_oe[cpu_sel*PORT_W + b]
                                  ? simple_out[cpu_sel][b] : sync2[cpu_sel*PORT_W + b];
                end
            end else begin
                next_rdata = RST_BYTE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cpu_rdata <= RST_BYTE;
            line_out  <= RST_LINES;
            line_oe   <= RST_LINES;
        end else begin
            cpu_rdata <= next_rdata;
            line_out  <= next_line_out; // [RQ1]
            line_oe   <= next_line_oe;
        end
    end
endmodule
`default_nettype wire

// ### src/pio_pkg.sv
// Shared constants and types for the 48-line parallel I/O block
package pio_pkg;
    localparam int PORT_W      = 8;
    localparam int NUM_PORTS   = 6;
    localparam int NUM_LINES   = 48;
    localparam int HALF_W      = 4;
    localparam int SEL_W       = 3;
    // Port indices as seen on the CPU select input
    localparam logic [2:0] SEL_P1 = 3'h0;
    localparam logic [2:0] SEL_P2 = 3'h1;
    localparam logic [2:0] SEL_P3 = 3'h2;
    // Control-port bit positions while port 3 carries handshakes
    localparam int CB_INTR_2   = 0;
    localparam int CB_FLAG_2   = 1;
    localparam int CB_HS_2     = 2;
    localparam int CB_INTR_1   = 3;
    localparam int CB_STB_1    = 4;
    localparam int CB_IBF_1    = 5;
    localparam int CB_ACK_1    = 6;
    localparam int CB_OBF_1    = 7;
    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [47:0] RST_LINES = 48'h0;
    typedef enum logic [2:0] {
        mode_in,
        mode_out,
        mode_strobe_in,
        mode_strobe_out,
        mode_bidir
    } port_mode_t;
endpackage

// ### src/strobe_channel.sv
// Latched and strobed handshake channel for one 8-bit port
`timescale 1ns/1ps
`default_nettype none
module strobe_channel (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire pio_pkg::port_mode_t          mode,
    input  wire logic                         strobe_fall,
    input  wire logic                         ack_fall,
    input  wire logic [pio_pkg::PORT_W-1:0]   pin_data,
    input  wire logic                         cpu_wr,
    input  wire logic                         cpu_rd,
    input  wire logic [pio_pkg::PORT_W-1:0]   wr_data,
    input  wire logic                         int_en,
    output logic      [pio_pkg::PORT_W-1:0]   in_latch,
    output logic      [pio_pkg::PORT_W-1:0]   out_latch,
    output logic                              in_full,
    output logic                              out_full,
    output logic                              irq
);
    import pio_pkg::*;
    logic                in_mode;
    logic                out_mode;
    logic                out_done;
    logic [PORT_W-1:0]   next_in_latch;
    logic [PORT_W-1:0]   next_out_latch;
    logic                next_in_full;
    logic                next_out_full;
    logic                next_out_done;

    assign in_mode  = (mode == mode_strobe_in) || (mode == mode_bidir);
    assign out_mode = (mode == mode_strobe_out) || (mode == mode_bidir);

    always_comb begin
        next_in_latch  = in_latch;
        next_out_latch = out_latch;
        next_in_full   = in_full;
        next_out_full  = out_full;
        next_out_done  = out_done;
        // Peripheral strobe latches data; set wins over CPU read
        if (in_mode && strobe_fall) begin // [RQ5]
            next_in_latch = pin_data;
            next_in_full  = 1'b1;
        end else if (cpu_rd || !in_mode) begin
            next_in_full = 1'b0;
        end
        if (cpu_wr) begin
            next_out_latch = wr_data;
        end
        // CPU write fills buffer; peripheral ack empties it
        if (out_mode && cpu_wr) begin
            next_out_full = 1'b1;
            next_out_done = 1'b0;
        end else if (!out_mode) begin
            next_out_full = 1'b0;
            next_out_done = 1'b0;
        end else if (ack_fall && out_full) begin // [RQ5]
            next_out_full = 1'b0;
            next_out_done = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            in_latch  <= RST_BYTE;
            out_latch <= RST_BYTE;
            in_full   <= 1'b0;
            out_full  <= 1'b0;
            out_done  <= 1'b0;
        end else begin
            in_latch  <= next_in_latch;
            out_latch <= next_out_latch;
            in_full   <= next_in_full;
            out_full  <= next_out_full;
            out_done  <= next_out_done;
        end
    end

    // Input buffer full or output byte taken raises the request
    assign irq = int_en && ((in_mode && in_full) || (out_mode && out_done)); // [RQ7]
endmodule
`default_nettype wire

// ### testbench/pio_checker.sv
// Port-level assertions for the parallel I/O block
`timescale 1ns/1ps
`default_nettype none
module pio_checker (
    input wire logic                          clk,
    input wire logic                          resetn,
    input wire pio_pkg::port_mode_t           port1_mode,
    input wire pio_pkg::port_mode_t           port2_mode,
    input wire logic [4:0]                    simple_dir,
    input wire logic [1:0]                    int_en,
    input wire logic [pio_pkg::SEL_W-1:0]     cpu_sel,
    input wire logic                          cpu_wr,
    input wire logic                          cpu_rd,
    input wire logic [pio_pkg::PORT_W-1:0]    cpu_wdata,
    input wire logic [pio_pkg::PORT_W-1:0]    cpu_rdata,
    input wire logic [1:0]                    irq,
    input wire logic [pio_pkg::NUM_LINES-1:0] line_in,
    input wire logic [pio_pkg::NUM_LINES-1:0] line_out,
    input wire logic [pio_pkg::NUM_LINES-1:0] line_oe
);
    import pio_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [11:0] prev1;
    logic [11:0] prev2;
    logic        calm;
    logic        ctl;
    // Configuration unchanged for two edges
    always_ff @(posedge clk) begin
        prev1 <= {simple_dir, port1_mode, port2_mode, resetn};
        prev2 <= prev1;
    end
    assign calm = (prev1 == {simple_dir, port1_mode, port2_mode, resetn}) && (prev2 == prev1);
    assign ctl = port1_mode inside {mode_strobe_in, mode_strobe_out, mode_bidir}
              || port2_mode inside {mode_strobe_in, mode_strobe_out};
    a_reset_clear: assert property (disable iff (1'b0) !resetn |=> line_out == 48'h0 && line_oe == 48'h0
        && cpu_rdata == 8'h00 && irq == 2'h0) else $error("outputs not cleared by reset");
    a_unmapped_read: assert property (cpu_rd && cpu_sel > 3'h5 |=> cpu_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!cpu_rd |=> $stable(cpu_rdata)) else $error("read data moved");
    a_simple_dir: assert property (calm |-> line_oe[47:24] == {{4{simple_dir[4]}}, {4{simple_dir[3]}},
        {8{simple_dir[2]}}, {8{simple_dir[1]}}}) else $error("simple port enables wrong");
    a_port3_dir: assert property (calm && !ctl |-> line_oe[23:16] == {8{simple_dir[0]}})
        else $error("port 3 enable wrong");
    a_ctl_inputs: assert property (calm && ctl |-> !line_oe[22] && !line_oe[20] && !line_oe[18])
        else $error("handshake input driven");
    a_p1_out: assert property (calm && port1_mode == mode_out |-> line_oe[7:0] == 8'hff)
        else $error("port 1 output not driven");
    a_p2_nobidir: assert property (calm && port2_mode inside {mode_in, mode_bidir} |-> line_oe[15:8] == 8'h00)
        else $error("port 2 driven as input");
    a_write_line: assert property (cpu_wr && cpu_sel == 3'h3 && calm && simple_dir[1]
        |-> ##2 line_out[31:24] == $past(cpu_wdata, 2)) else $error("port 4 write not on lines");
    a_strobe_fill: assert property (port1_mode == mode_strobe_in && int_en[0] && calm && $fell(line_in[20])
        |-> ##[2:6] irq[0]) else $error("strobe gave no request");
    a_obf_low: assert property (port1_mode == mode_strobe_out && calm && cpu_wr && cpu_sel == 3'h0
        |-> ##2 !line_out[23]) else $error("output full not signalled");
    a_irq_mask: assert property ((irq & ~int_en) == 2'h0) else $error("masked request raised");
    c_strobe: cover property (port1_mode == mode_strobe_in && irq[0]);
    c_out_done: cover property (port1_mode == mode_strobe_out && irq[0]);
    c_unmapped: cover property (cpu_rd && cpu_sel > 3'h5);
    c_port2_fill: cover property (port2_mode == mode_strobe_in && irq[1]);
endmodule
bind parallel_io_port_config pio_checker u_chk (.clk(clk), .resetn(resetn), .port1_mode(port1_mode),
    .port2_mode(port2_mode), .simple_dir(simple_dir), .int_en(int_en), .cpu_sel(cpu_sel), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .irq(irq), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe));
`default_nettype wire

// ### testbench/pio_peripheral.sv
// Peripheral model on the parallel connectors
`timescale 1ns/1ps
`default_nettype none
module pio_peripheral (
    input  wire logic [47:0] line_out,
    input  wire logic [47:0] line_oe,
    input  wire logic [47:0] drv,
    input  wire logic        hs,
    input  wire logic        stb_n,
    input  wire logic        ack_n,
    output logic      [47:0] line_in
);
    logic [47:0] ext;
    always_comb begin
        ext = drv;
        if (hs) begin
            ext[20] = stb_n;
            ext[22] = ack_n;
        end
        for (int i = 0; i < 48; i++) begin
            line_in[i] = line_oe[i] ? line_out[i] : ext[i];
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the parallel I/O block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    import pio_pkg::*;
    typedef struct packed {logic [2:0] sel; logic [7:0] val; logic [7:0] exp_rd;} row_t;
    logic        clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, hs = 1'b0, stb_n = 1'b1, ack_n = 1'b1;
    port_mode_t  p1m = mode_in, p2m = mode_in;
    logic [4:0]  dir = 5'h00;
    logic [1:0]  ien = 2'h0, irq;
    logic [2:0]  sel = 3'h0;
    logic [7:0]  wdata = 8'h00, rdata, got;
    logic [47:0] lin, lout, loe, drv = 48'h0;
    int          fail_count = 0, checks = 0, cycles = 0;
    row_t        rows [8] = '{'{3'h0, 8'ha5, 8'ha5}, '{3'h1, 8'h3c, 8'h3c}, '{3'h2, 8'h81, 8'h81},
        '{3'h3, 8'h7e, 8'h7e}, '{3'h4, 8'h01, 8'h01}, '{3'h5, 8'hf0, 8'hf0}, '{3'h6, 8'h55, 8'h00},
        '{3'h7, 8'haa, 8'h00}};
    parallel_io_port_config DUT (.clk(clk), .resetn(resetn), .port1_mode(p1m), .port2_mode(p2m),
        .simple_dir(dir), .int_en(ien), .cpu_sel(sel), .cpu_wr(wr), .cpu_rd(rd), .cpu_wdata(wdata),
        .cpu_rdata(rdata), .irq(irq), .line_in(lin), .line_out(lout), .line_oe(loe));
    pio_peripheral u_per (.line_out(lout), .line_oe(loe), .drv(drv), .hs(hs), .stb_n(stb_n),
        .ack_n(ack_n), .line_in(lin));
    always #2.5 clk = ~clk;
    task automatic final_report();
        if (fail_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr_b(input logic [2:0] s, input logic [7:0] d);
        sel = s; wdata = d; wr = 1'b1;
        tick(1);
        wr = 1'b0;
    endtask
    task automatic rd_b(input logic [2:0] s);
        sel = s; rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(1);
        got = rdata;
    endtask
    initial begin
        tick(12);
        resetn = 1'b1;
        tick(1);
        `CHK(loe, 48'h0)
        foreach (rows[i]) begin
            p1m = mode_in; p2m = mode_in; dir = 5'h00; drv = {6{rows[i].val}};
            tick(4);
            rd_b(rows[i].sel);
            `CHK(got, rows[i].exp_rd)
            p1m = mode_out; p2m = mode_out; dir = 5'h1f;
            tick(2);
            wr_b(rows[i].sel, rows[i].val);
            tick(3);
            if (rows[i].sel < 3'h6) begin
                `CHK(lout[rows[i].sel*8 +: 8], rows[i].val)
                `CHK(loe[rows[i].sel*8 +: 8], 8'hff)
            end
        end
        // Strobed input, masked then unmasked
        p1m = mode_strobe_in; p2m = mode_in; dir = 5'h00; hs = 1'b1; drv = {6{8'h96}};
        for (int m = 0; m < 2; m++) begin
            ien = m[1:0];
            tick(3);
            stb_n = 1'b0; tick(4); stb_n = 1'b1; tick(4);
            `CHK(irq[0], m[0])
            `CHK(lout[21], 1'b1)
            rd_b(SEL_P1);
            `CHK(got, 8'h96)
            tick(1);
            `CHK(irq[0], 1'b0)
        end
        // Strobed output taken by an ack
        p1m = mode_strobe_out; ien = 2'h1;
        tick(3);
        wr_b(SEL_P1, 8'h5a);
        tick(3);
        `CHK(lout[23], 1'b0)
        `CHK(lout[7:0], 8'h5a)
        ack_n = 1'b0; tick(4); ack_n = 1'b1; tick(4);
        `CHK(lout[23], 1'b1)
        `CHK(irq[0], 1'b1)
        // Port 2 strobed input on the shared handshake line
        p1m = mode_in; p2m = mode_strobe_in; ien = 2'h2;
        tick(3);
        drv[18] = 1'b0; tick(4); drv[18] = 1'b1; tick(4);
        `CHK(irq, 2'h2)
        `CHK(lout[17], 1'b1)
        rd_b(SEL_P2);
        `CHK(got, 8'h96)
        tick(1);
        `CHK(irq[1], 1'b0)
        ien = 2'h3;
        p2m = mode_bidir; p1m = mode_bidir;
        tick(4);
        `CHK(loe[15:8], 8'h00)
        `CHK(loe[7:0], 8'h00)
        ack_n = 1'b0; tick(5);
        `CHK(loe[7:0], 8'hff)
        ack_n = 1'b1; resetn = 1'b0;
        tick(2);
        `CHK({lout, loe, irq}, 98'h0)
        resetn = 1'b1;
        tick(2);
        `CHK(irq, 2'h0)
        `CHK(loe[7:0], 8'h00)
        final_report();
    end
endmodule
`default_nettype wire
